// ==== design/epiu_pkg.sv ====
// package: constants, register map and carrier types of the pin interrupt unit
package epiu_pkg;

    // ****************************************
    // widths
    // ****************************************
    localparam int EPIU_AW = 8;
    localparam int EPIU_DW = 32;
    localparam int EPIU_RW = 8;
    localparam int EPIU_LINES = 16;
    localparam int EPIU_GROUP = 8;

    // ****************************************
    // register map (byte addresses)
    // ****************************************
    localparam logic [EPIU_AW-1:0] EPIU_OFF_SENSE = 8'h00;
    localparam logic [EPIU_AW-1:0] EPIU_OFF_ENABLE = 8'h04;
    localparam logic [EPIU_AW-1:0] EPIU_OFF_FLAGS = 8'h08;
    localparam logic [EPIU_AW-1:0] EPIU_OFF_MASK_UP = 8'h0c;
    localparam logic [EPIU_AW-1:0] EPIU_OFF_MASK_LO = 8'h10;

    // ****************************************
    // fields and reset values
    // ****************************************
    localparam int EPIU_BIT_UPPER = 7;
    localparam int EPIU_BIT_LOWER = 6;
    localparam int EPIU_BIT_PIN = 0;
    localparam logic [EPIU_RW-1:0] EPIU_EN_IMPL = 8'hc1;
    localparam logic [EPIU_RW-1:0] EPIU_SENSE_IMPL = 8'h03;
    localparam logic [EPIU_RW-1:0] EPIU_REG_RESET = 8'h00;

    // sense select encodings {hi, lo}
    localparam logic [1:0] EPIU_SENSE_LOW = 2'h0;
    localparam logic [1:0] EPIU_SENSE_ANY = 2'h1;
    localparam logic [1:0] EPIU_SENSE_FALL = 2'h2;
    localparam logic [1:0] EPIU_SENSE_RISE = 2'h3;

    // bus answers
    localparam logic [1:0] EPIU_RESP_OKAY = 2'h0;
    localparam logic [1:0] EPIU_RESP_SLVERR = 2'h2;

    // ****************************************
    // carrier types
    // ****************************************
    typedef struct packed {
        logic awvalid;
        logic [EPIU_AW-1:0] awaddr;
        logic wvalid;
        logic [EPIU_DW-1:0] wdata;
        logic [3:0] wstrb;
        logic bready;
        logic arvalid;
        logic [EPIU_AW-1:0] araddr;
        logic rready;
    } epiu_axi_req_t;

    typedef struct packed {
        logic awready;
        logic wready;
        logic bvalid;
        logic [1:0] bresp;
        logic arready;
        logic rvalid;
        logic [EPIU_DW-1:0] rdata;
        logic [1:0] rresp;
    } epiu_axi_resp_t;

    typedef struct packed {
        logic pin_entered;
        logic upper_entered;
        logic lower_entered;
    } epiu_ack_t;

    typedef struct packed {
        logic pin_req;
        logic upper_group_change_request;
        logic lower_group_change_request;
        logic wake;
    } epiu_irq_t;

endpackage : epiu_pkg

// ==== design/epiu_top.sv ====
// pin interrupt unit: dedicated pin and sixteen pin-change lines behind axi4-lite
// Function
// R1: interrupts fire even when pins are outputs
// R2: upper group requests on unmasked line toggle
// R3: lower group requests on unmasked line toggle
// R4: pin-change detection needs no running clock; here the lines are sampled on core_clk
// R5: low level requests while pin stays low
// R6: edge detection runs on io clock only
// R7: low-level detection needs no running clock; here the pin is sampled on core_clk
// R8: level wake interrupts only if still low
// R9: pin request needs global flag and enable
// R10: pin sampled first; wider pulses always caught
// R11: source holds low level past current instruction
// R12: sense field picks low, change, fall, rise
// R13: enable bit 7 gates upper group request
// R14: enable bit 6 gates lower group request
// R15: enable bit 0 gates dedicated pin request
// R16: flag 7 sets on upper change, clears
// R17: flag 6 sets on lower change, clears
// R18: flag 0 sets on pin edge, clears
// R19: flag 0 held clear in level mode
// R20: upper mask bits gate lines, reset zero
// R21: lower mask bits gate lines, reset zero
// R22: pin synchronised twice, flag one clock later
// R23: hardware set wins over software clear
module epiu_top (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst_b,
    // register bus
    input wire epiu_pkg::epiu_axi_req_t axi_req,
    output epiu_pkg::epiu_axi_resp_t axi_resp,
    // pins, sampled as pad levels whatever the direction
    input wire logic dedicated_irq_pin,
    input wire logic [epiu_pkg::EPIU_LINES-1:0] pin_change_lines,
    // cpu side
    input wire logic global_irq_enable,
    input wire epiu_pkg::epiu_ack_t handler_ack,
    output epiu_pkg::epiu_irq_t irq_out
);
    import epiu_pkg::*;

    // ****************************************
    // pin synchronisers
    // ****************************************
    // the asynchronous wake paths are modelled on core_clk here;
    // a real part adds a clockless latch in front of this
    logic pin_s1_q, pin_s2_q, pin_prev_q;
    logic pin_s1_d, pin_s2_d, pin_prev_d;
    logic [EPIU_LINES-1:0] pc_s1_q, pc_s2_q, pc_prev_q;
    logic [EPIU_LINES-1:0] pc_s1_d, pc_s2_d, pc_prev_d;

    always_comb begin
        pin_s1_d = dedicated_irq_pin; // [R1]
        pin_s2_d = pin_s1_q; // [R22]
        pin_prev_d = pin_s2_q;
        pc_s1_d = pin_change_lines; // [R1]
        pc_s2_d = pc_s1_q;
        pc_prev_d = pc_s2_q;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            pin_s1_q <= 1'b1;
            pin_s2_q <= 1'b1;
            pin_prev_q <= 1'b1;
            pc_s1_q <= '0;
            pc_s2_q <= '0;
            pc_prev_q <= '0;
        end else begin
            pin_s1_q <= pin_s1_d;
            pin_s2_q <= pin_s2_d;
            pin_prev_q <= pin_prev_d;
            pc_s1_q <= pc_s1_d;
            pc_s2_q <= pc_s2_d;
            pc_prev_q <= pc_prev_d;
        end
    end

    // ****************************************
    // bus slave state
    // ****************************************
    epiu_axi_resp_t resp_q, resp_d;
    logic aw_held_q, aw_held_d;
    logic w_held_q, w_held_d;
    logic [EPIU_AW-1:0] awaddr_q, awaddr_d;
    logic [EPIU_RW-1:0] wdata_q, wdata_d;
    logic wstrb0_q, wstrb0_d;
    logic wr_go;
    logic wr_hit;
    logic [EPIU_RW-1:0] rd_val;
    logic rd_hit;

    // registers
    logic [EPIU_RW-1:0] sense_q, sense_d;
    logic [EPIU_RW-1:0] enable_q, enable_d;
    logic [EPIU_RW-1:0] flags_q, flags_d;
    logic [EPIU_RW-1:0] mask_up_q, mask_up_d;
    logic [EPIU_RW-1:0] mask_lo_q, mask_lo_d;

    // a write is done once both address and data are held
    assign wr_go = aw_held_q && w_held_q && !resp_q.bvalid;

    always_comb begin
        wr_hit = 1'b1;
        unique case (awaddr_q[EPIU_AW-1:2])
            EPIU_OFF_SENSE[EPIU_AW-1:2]: wr_hit = 1'b1;
            EPIU_OFF_ENABLE[EPIU_AW-1:2]: wr_hit = 1'b1;
            EPIU_OFF_FLAGS[EPIU_AW-1:2]: wr_hit = 1'b1;
            EPIU_OFF_MASK_UP[EPIU_AW-1:2]: wr_hit = 1'b1;
            EPIU_OFF_MASK_LO[EPIU_AW-1:2]: wr_hit = 1'b1;
            default: wr_hit = 1'b0;
        endcase
    end

    always_comb begin
        rd_val = '0;
        rd_hit = 1'b1;
        unique case (axi_req.araddr[EPIU_AW-1:2])
            EPIU_OFF_SENSE[EPIU_AW-1:2]: rd_val = sense_q;
            EPIU_OFF_ENABLE[EPIU_AW-1:2]: rd_val = enable_q;
            EPIU_OFF_FLAGS[EPIU_AW-1:2]: rd_val = flags_q;
            EPIU_OFF_MASK_UP[EPIU_AW-1:2]: rd_val = mask_up_q;
            EPIU_OFF_MASK_LO[EPIU_AW-1:2]: rd_val = mask_lo_q;
            default: rd_hit = 1'b0;
        endcase
    end

    always_comb begin
        resp_d = resp_q;
        aw_held_d = aw_held_q;
        w_held_d = w_held_q;
        awaddr_d = awaddr_q;
        wdata_d = wdata_q;
        wstrb0_d = wstrb0_q;
        if (axi_req.awvalid && resp_q.awready) begin
            aw_held_d = 1'b1;
            awaddr_d = axi_req.awaddr;
        end
        if (axi_req.wvalid && resp_q.wready) begin
            w_held_d = 1'b1;
            wdata_d = axi_req.wdata[EPIU_RW-1:0];
            wstrb0_d = axi_req.wstrb[0];
        end
        if (wr_go) begin
            aw_held_d = 1'b0;
            w_held_d = 1'b0;
            resp_d.bvalid = 1'b1;
            resp_d.bresp = wr_hit ? EPIU_RESP_OKAY : EPIU_RESP_SLVERR;
        end else if (resp_q.bvalid && axi_req.bready) begin
            resp_d.bvalid = 1'b0;
        end
        // one write in flight: no new address or data until answered
        resp_d.awready = !aw_held_d && !resp_d.bvalid;
        resp_d.wready = !w_held_d && !resp_d.bvalid;
        if (axi_req.arvalid && resp_q.arready) begin
            resp_d.rvalid = 1'b1;
            resp_d.rdata = {{(EPIU_DW-EPIU_RW){1'b0}}, rd_val};
            resp_d.rresp = rd_hit ? EPIU_RESP_OKAY : EPIU_RESP_SLVERR;
        end else if (resp_q.rvalid && axi_req.rready) begin
            resp_d.rvalid = 1'b0;
        end
        resp_d.arready = !resp_d.rvalid;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            resp_q <= '0;
            aw_held_q <= 1'b0;
            w_held_q <= 1'b0;
            awaddr_q <= '0;
            wdata_q <= '0;
            wstrb0_q <= 1'b0;
        end else begin
            resp_q <= resp_d;
            aw_held_q <= aw_held_d;
            w_held_q <= w_held_d;
            awaddr_q <= awaddr_d;
            wdata_q <= wdata_d;
            wstrb0_q <= wstrb0_d;
        end
    end

    assign axi_resp = resp_q;

    // ****************************************
    // event detection
    // ****************************************
    logic level_mode;
    logic pin_edge;
    logic [EPIU_LINES-1:0] line_hit;
    logic [EPIU_LINES-1:0] line_mask;
    logic upper_hit, lower_hit;

    assign level_mode = sense_q[1:0] == EPIU_SENSE_LOW;
    assign line_mask = {mask_up_q, mask_lo_q};

    // edges compare sampled values, so any pulse wider than one clock is seen
    always_comb begin
        pin_edge = 1'b0;
        unique case (sense_q[1:0]) // [R12]
            EPIU_SENSE_LOW: pin_edge = 1'b0;
            EPIU_SENSE_ANY: pin_edge = pin_s2_q ^ pin_prev_q; // [R10]
            EPIU_SENSE_FALL: pin_edge = pin_prev_q && !pin_s2_q; // [R6]
            EPIU_SENSE_RISE: pin_edge = !pin_prev_q && pin_s2_q; // [R6]
        endcase
    end

    for (genvar i = 0; i < EPIU_LINES; i++) begin : g_line
        localparam int GB = (i < EPIU_GROUP) ? EPIU_BIT_LOWER : EPIU_BIT_UPPER;
        // [R20] [R21] [R4]
        assign line_hit[i] = (pc_s2_q[i] ^ pc_prev_q[i]) && line_mask[i] && enable_q[GB];
    end

    assign upper_hit = |line_hit[EPIU_LINES-1:EPIU_GROUP]; // [R2]
    assign lower_hit = |line_hit[EPIU_GROUP-1:0]; // [R3]

    // ****************************************
    // register file
    // ****************************************
    always_comb begin
        sense_d = sense_q;
        enable_d = enable_q;
        mask_up_d = mask_up_q;
        mask_lo_d = mask_lo_q;
        flags_d = flags_q;
        if (wr_go && wstrb0_q) begin
            unique case (awaddr_q[EPIU_AW-1:2])
                EPIU_OFF_SENSE[EPIU_AW-1:2]: sense_d = wdata_q & EPIU_SENSE_IMPL;
                EPIU_OFF_ENABLE[EPIU_AW-1:2]: enable_d = wdata_q & EPIU_EN_IMPL;
                EPIU_OFF_FLAGS[EPIU_AW-1:2]: flags_d = flags_q & ~wdata_q;
                EPIU_OFF_MASK_UP[EPIU_AW-1:2]: mask_up_d = wdata_q;
                EPIU_OFF_MASK_LO[EPIU_AW-1:2]: mask_lo_d = wdata_q;
                default: flags_d = flags_q;
            endcase
        end
        // entering a handler clears its flag
        if (handler_ack.upper_entered) begin
            flags_d[EPIU_BIT_UPPER] = 1'b0; // [R16]
        end
        if (handler_ack.lower_entered) begin
            flags_d[EPIU_BIT_LOWER] = 1'b0; // [R17]
        end
        if (handler_ack.pin_entered) begin
            flags_d[EPIU_BIT_PIN] = 1'b0; // [R18]
        end
        // sets follow the write and handler clears so that a same-cycle clear cannot eat an event
        if (upper_hit) begin
            flags_d[EPIU_BIT_UPPER] = 1'b1; // [R16] [R23]
        end
        if (lower_hit) begin
            flags_d[EPIU_BIT_LOWER] = 1'b1; // [R17] [R23]
        end
        if (pin_edge) begin
            flags_d[EPIU_BIT_PIN] = 1'b1; // [R18] [R22] [R23]
        end
        if (level_mode) begin
            flags_d[EPIU_BIT_PIN] = 1'b0; // [R19]
        end
        flags_d = flags_d & EPIU_EN_IMPL;
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            sense_q <= EPIU_REG_RESET;
            enable_q <= EPIU_REG_RESET;
            flags_q <= EPIU_REG_RESET;
            mask_up_q <= EPIU_REG_RESET; // [R20]
            mask_lo_q <= EPIU_REG_RESET; // [R21]
        end else begin
            sense_q <= sense_d;
            enable_q <= enable_d;
            flags_q <= flags_d;
            mask_up_q <= mask_up_d;
            mask_lo_q <= mask_lo_d;
        end
    end

    // ****************************************
    // requests to the cpu
    // ****************************************
    epiu_irq_t irq_q, irq_d;
    logic pin_active;

    // level mode follows the live pin, so a level gone by start-up end
    // wakes without a request
    assign pin_active = level_mode ? !pin_s2_q : flags_q[EPIU_BIT_PIN]; // [R5] [R8]

    always_comb begin
        irq_d.pin_req = global_irq_enable && enable_q[EPIU_BIT_PIN] && pin_active; // [R9] [R15]
        irq_d.upper_group_change_request = global_irq_enable
            && enable_q[EPIU_BIT_UPPER] && flags_q[EPIU_BIT_UPPER]; // [R13]
        irq_d.lower_group_change_request = global_irq_enable
            && enable_q[EPIU_BIT_LOWER] && flags_q[EPIU_BIT_LOWER]; // [R14]
        // wake ignores the global flag; only edges need the io clock
        irq_d.wake = (enable_q[EPIU_BIT_PIN] && level_mode && !pin_s2_q) // [R7]
            || (enable_q[EPIU_BIT_UPPER] && flags_q[EPIU_BIT_UPPER]) // [R4]
            || (enable_q[EPIU_BIT_LOWER] && flags_q[EPIU_BIT_LOWER]);
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            irq_q <= '0;
        end else begin
            irq_q <= irq_d;
        end
    end

    assign irq_out = irq_q;

    // ****************************************
    // assertions
    // ****************************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!rst_b);

    sequence s_pin_rise;
        sense_q[1:0] == EPIU_SENSE_RISE && $rose(pin_s2_q);
    endsequence

    sequence s_pin_fall;
        sense_q[1:0] == EPIU_SENSE_FALL && $fell(pin_s2_q);
    endsequence

    sequence s_flag_w1c(int b);
        wr_go && wstrb0_q && awaddr_q == EPIU_OFF_FLAGS && wdata_q[b];
    endsequence

    rise_sense_a: assert property (s_pin_rise |=> flags_q[EPIU_BIT_PIN]) // [R12]
        else $error("rising edge did not set pin flag");

    fall_sense_a: assert property (s_pin_fall |=> flags_q[EPIU_BIT_PIN]) // [R18]
        else $error("falling edge did not set pin flag");

    level_clear_a: assert property (level_mode |=> !flags_q[EPIU_BIT_PIN]) // [R19]
        else $error("pin flag set in level mode");

    pin_origin_a: assert property ($rose(flags_q[EPIU_BIT_PIN]) |-> $past(pin_edge)) // [R22]
        else $error("pin flag rose without an edge");

    upper_set_a: assert property (upper_hit |=> flags_q[EPIU_BIT_UPPER]) // [R23]
        else $error("upper change lost");

    upper_origin_a: assert property ($rose(flags_q[EPIU_BIT_UPPER]) |-> $past(upper_hit)) // [R2]
        else $error("upper flag rose without a change");

    lower_ack_a: assert property (handler_ack.lower_entered && !lower_hit // [R17]
        |=> !flags_q[EPIU_BIT_LOWER])
        else $error("lower flag not cleared on handler entry");

    upper_w1c_a: assert property (s_flag_w1c(EPIU_BIT_UPPER) && !upper_hit // [R16]
        |=> !flags_q[EPIU_BIT_UPPER])
        else $error("upper flag not cleared by write one");

    level_req_a: assert property (global_irq_enable && enable_q[EPIU_BIT_PIN] // [R5]
        && level_mode && !pin_s2_q |=> irq_out.pin_req)
        else $error("low level did not raise pin request");

    gie_gate_a: assert property (!global_irq_enable |=> !irq_out.pin_req // [R9]
        && !irq_out.upper_group_change_request
        && !irq_out.lower_group_change_request)
        else $error("request without global flag");

    lower_gate_a: assert property (!enable_q[EPIU_BIT_LOWER] |-> !lower_hit) // [R14]
        else $error("lower line seen with group disabled");

    write_resp_a: assert property (wr_go |=> axi_resp.bvalid [*1] ##0 !axi_resp.awready)
        else $error("write not answered one cycle after both held");

endmodule : epiu_top

// ==== sim/epiu_pin_model.sv ====
// pin model: board logic driving the dedicated pin and the pin-change pads
module epiu_pin_model (
    // clock
    input wire logic core_clk,
    // pad levels, whatever the pin direction inside the part
    output logic dedicated_irq_pin,
    output logic [epiu_pkg::EPIU_LINES-1:0] pin_change_lines
);
    timeunit 1ns;
    timeprecision 1ps;
    import epiu_pkg::*;

    // pin idles high as a pulled-up pad, lines start low
    initial begin
        dedicated_irq_pin = 1'b1;
        pin_change_lines = '0;
    end

    // each new level is held at least three clocks, so no pulse is one period or less
    task automatic drive(input logic p, input logic [EPIU_LINES-1:0] l);
        @(posedge core_clk);
        dedicated_irq_pin <= p;
        pin_change_lines <= l;
        repeat (2) @(posedge core_clk);
    endtask : drive
endmodule : epiu_pin_model

// ==== sim/testbench.sv ====
// testbench: pin interrupt unit over axi4-lite, its pads and cpu side
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    import epiu_pkg::*;

    // ********************
    // signals and instances
    // ********************
    logic core_clk;
    logic rst_b;
    epiu_axi_req_t req;
    epiu_axi_resp_t resp;
    logic dedicated_irq_pin;
    logic [EPIU_LINES-1:0] pin_change_lines;
    logic global_irq_enable;
    epiu_ack_t ack;
    epiu_irq_t irq;
    int num_errors = 0;
    int checked = 0;

    epiu_top DUT (
        .core_clk(core_clk),
        .rst_b(rst_b),
        .axi_req(req),
        .axi_resp(resp),
        .dedicated_irq_pin(dedicated_irq_pin),
        .pin_change_lines(pin_change_lines),
        .global_irq_enable(global_irq_enable),
        .handler_ack(ack),
        .irq_out(irq)
    );

    epiu_pin_model u_pins (
        .core_clk(core_clk),
        .dedicated_irq_pin(dedicated_irq_pin),
        .pin_change_lines(pin_change_lines)
    );

    initial begin
        core_clk = 1'b0;
        forever #12.5 core_clk = ~core_clk;
    end

    // ********************
    // helpers
    // ********************
    task automatic chk(input string w, input logic [31:0] e, input logic [31:0] g);
        checked++;
        if (g !== e) begin
            $display("ERROR %s expected %h seen %h", w, e, g);
            num_errors++;
        end
    endtask : chk

    task automatic chkb(input string w, input logic e, input logic g);
        chk(w, {31'h0, e}, {31'h0, g});
    endtask : chkb

    // no cycle count assumed: only the watchdog ends a hung wait;
    // bready and rready stay up between calls, so no edge assigns them twice
    task automatic wr(input logic [7:0] a, input logic [7:0] d, input logic [3:0] s,
                      input logic [1:0] er);
        req.awvalid <= 1'b1;
        req.awaddr <= a;
        req.wvalid <= 1'b1;
        req.wdata <= {24'h0, d};
        req.wstrb <= s;
        req.bready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (resp.awready === 1'b1) req.awvalid <= 1'b0;
            if (resp.wready === 1'b1) req.wvalid <= 1'b0;
        end while (resp.bvalid !== 1'b1);
        chkb("bvalid", 1'b1, resp.bvalid);
        chk("bresp", {30'h0, er}, {30'h0, resp.bresp});
    endtask : wr

    task automatic rd(input logic [7:0] a, input logic [7:0] ed, input logic [1:0] er);
        req.arvalid <= 1'b1;
        req.araddr <= a;
        req.rready <= 1'b1;
        do begin
            @(posedge core_clk);
            if (resp.arready === 1'b1) req.arvalid <= 1'b0;
        end while (resp.rvalid !== 1'b1);
        chkb("rvalid", 1'b1, resp.rvalid);
        chk("rdata", {24'h0, ed}, resp.rdata);
        chk("rresp", {30'h0, er}, {30'h0, resp.rresp});
    endtask : rd

    task automatic wro(input logic [7:0] a, input logic [7:0] d);
        wr(a, d, 4'h1, EPIU_RESP_OKAY);
    endtask : wro

    task automatic rdf(input logic [7:0] e);
        rd(EPIU_OFF_FLAGS, e, EPIU_RESP_OKAY);
    endtask : rdf

    task automatic idle(input int n);
        repeat (n) @(posedge core_clk);
    endtask : idle

    // ********************
    // scenarios
    // ********************
    task automatic t_regs();
        logic [7:0] offs [5] = '{EPIU_OFF_SENSE, EPIU_OFF_ENABLE, EPIU_OFF_FLAGS,
                                 EPIU_OFF_MASK_UP, EPIU_OFF_MASK_LO};
        foreach (offs[i]) rd(offs[i], EPIU_REG_RESET, EPIU_RESP_OKAY);
        rd(8'h14, 8'h00, EPIU_RESP_SLVERR);
        wr(8'h14, 8'hff, 4'h1, EPIU_RESP_SLVERR);
        wr(EPIU_OFF_MASK_LO, 8'h5a, 4'h0, EPIU_RESP_OKAY);
        rd(EPIU_OFF_MASK_LO, 8'h00, EPIU_RESP_OKAY);
        wro(EPIU_OFF_MASK_UP, 8'ha5);
        rd(EPIU_OFF_MASK_UP, 8'ha5, EPIU_RESP_OKAY);
        wro(EPIU_OFF_SENSE, 8'hff);
        rd(EPIU_OFF_SENSE, EPIU_SENSE_IMPL, EPIU_RESP_OKAY);
        wro(EPIU_OFF_ENABLE, 8'hff);
        rd(EPIU_OFF_ENABLE, EPIU_EN_IMPL, EPIU_RESP_OKAY);
    endtask : t_regs

    // every edge mode sees one fall and one rise of the pin
    task automatic t_sense();
        logic [1:0] m;
        logic e;
        global_irq_enable <= 1'b1;
        wro(EPIU_OFF_ENABLE, 8'h01);
        for (int i = 1; i < 4; i++) begin
            m = i[1:0];
            wro(EPIU_OFF_SENSE, {6'h0, m});
            rd(EPIU_OFF_SENSE, {6'h0, m}, EPIU_RESP_OKAY);
            wro(EPIU_OFF_FLAGS, 8'h01);
            e = (m != EPIU_SENSE_RISE);
            u_pins.drive(1'b0, 16'h0000);
            idle(2);
            chkb("pin_req early", 1'b0, irq.pin_req);
            idle(2);
            chkb("pin_req fall", e, irq.pin_req);
            rdf({7'h0, e});
            wro(EPIU_OFF_FLAGS, 8'h01);
            e = (m != EPIU_SENSE_FALL);
            u_pins.drive(1'b1, 16'h0000);
            idle(4);
            chkb("pin_req rise", e, irq.pin_req);
            rdf({7'h0, e});
        end
        wro(EPIU_OFF_FLAGS, 8'h01);
        rdf(8'h00);
    endtask : t_sense

    task automatic t_level();
        wro(EPIU_OFF_SENSE, {6'h0, EPIU_SENSE_LOW});
        u_pins.drive(1'b0, 16'h0000);
        idle(3);
        chkb("pin_req low", 1'b1, irq.pin_req);
        rdf(8'h00);
        chkb("pin_req held", 1'b1, irq.pin_req);
        global_irq_enable <= 1'b0;
        idle(3);
        chkb("pin_req gated", 1'b0, irq.pin_req);
        chkb("wake low", 1'b1, irq.wake);
        u_pins.drive(1'b1, 16'h0000);
        idle(3);
        chkb("wake gone", 1'b0, irq.wake);
    endtask : t_level

    task automatic t_groups();
        global_irq_enable <= 1'b1;
        wro(EPIU_OFF_SENSE, {6'h0, EPIU_SENSE_RISE});
        wro(EPIU_OFF_MASK_UP, 8'h02);
        wro(EPIU_OFF_MASK_LO, 8'h08);
        wro(EPIU_OFF_ENABLE, 8'hc0);
        wro(EPIU_OFF_FLAGS, 8'hc1);
        u_pins.drive(1'b1, 16'h0400);
        idle(4);
        rdf(8'h00);
        u_pins.drive(1'b1, 16'h0600);
        idle(4);
        chkb("upper req", 1'b1, irq.upper_group_change_request);
        chkb("lower req", 1'b0, irq.lower_group_change_request);
        rdf(8'h80);
        u_pins.drive(1'b1, 16'h0608);
        idle(4);
        chkb("lower req", 1'b1, irq.lower_group_change_request);
        rdf(8'hc0);
        ack.upper_entered <= 1'b1;
        @(posedge core_clk);
        ack.upper_entered <= 1'b0;
        idle(2);
        rdf(8'h40);
        wro(EPIU_OFF_FLAGS, 8'h40);
        rdf(8'h00);
        wro(EPIU_OFF_ENABLE, 8'h80);
        u_pins.drive(1'b1, 16'h0600);
        idle(4);
        rdf(8'h00);
        wro(EPIU_OFF_ENABLE, 8'hc0);
        u_pins.drive(1'b1, 16'h0608);
        idle(4);
        // flag cleared first, so only the racing set can leave it up
        wro(EPIU_OFF_FLAGS, 8'h40);
        // handler entry lands on the very edge of a second set
        u_pins.drive(1'b1, 16'h0600);
        ack.lower_entered <= 1'b1;
        @(posedge core_clk);
        ack.lower_entered <= 1'b0;
        idle(2);
        rdf(8'h40);
        global_irq_enable <= 1'b0;
        idle(2);
        chkb("lower gated", 1'b0, irq.lower_group_change_request);
        chkb("wake group", 1'b1, irq.wake);
        // plain handler entry with no change pending
        ack.lower_entered <= 1'b1;
        @(posedge core_clk);
        ack.lower_entered <= 1'b0;
        idle(2);
        rdf(8'h00);
        chkb("wake cleared", 1'b0, irq.wake);
    endtask : t_groups

    // ********************
    // run control
    // ********************
    task automatic stop_test();
        if (num_errors == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : stop_test

    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        stop_test();
    end

    initial begin
        rst_b = 1'b0;
        req = '0;
        global_irq_enable = 1'b0;
        ack = '0;
        repeat (16) @(posedge core_clk);
        rst_b <= 1'b1;
        idle(2);
        t_regs();
        t_sense();
        t_level();
        t_groups();
        stop_test();
    end
endmodule : testbench
